/* design/xy_seq_cfg.svh */
// Timing and reset constants of the X-Y point sequencer
`ifndef XY_SEQ_CFG_SVH
`define XY_SEQ_CFG_SVH
`define XY_CLK_MHZ          100
`define XY_IDLE_STEP_NS     25
`define XY_IDLE_STEP_CYC    ((`XY_IDLE_STEP_NS * `XY_CLK_MHZ + 999) / 1000)
`define XY_OVERHEAD_NS      500
`define XY_OVERHEAD_CYC     ((`XY_OVERHEAD_NS * `XY_CLK_MHZ) / 1000)
`define XY_COORD_MAX        12'hfff
`define XY_THRESH_RST       12'h3e8
`define XY_SMALL_RST        8'h19
`define XY_LARGE_RST        8'h32
`define XY_UNBLANK_RST      8'h05
`define XY_FRAME_MS         20
`endif

/* design/xy_seq_pkg.sv */
// Types of the X-Y point sequencer
package xy_seq_pkg;
  typedef logic [11:0] coord_t;
  typedef logic [7:0]  count_t;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_LOAD_X = 3'b001,
    ST_LOAD_Y = 3'b011,
    ST_SETTLE = 3'b010,
    ST_BEAM   = 3'b110,
    ST_OFF    = 3'b111
  } seq_state_e;
endpackage : xy_seq_pkg

/* design/xy_vector_point_sequencer.sv */
// X-Y vector point sequencer: converter loads, settling delay, beam pulse
//
// Contract
// R1 - Beam pulse width set by programmable count
// R2 - Point period: overhead plus settle plus pulse
// R3 - Beam held low through whole settling
// R4 - Separate short and long settling counts
// R5 - Below threshold short, at or above long
// R6 - Each count unit adds one idle step
// R7 - Zero counts give about 500 ns period
// R8 - Keep period short for 20 ms redraw
// R9 - Four settings readable and writable at runtime
// R10 - Pulse count reported back when queried
// R11 - Coordinates span 0 to 4095 per axis
// R12 - Load X, then Y, settle, then beam
// R13 - Beam low again before next point
// R14 - Absolute per-axis difference picks long count
`timescale 1ns/1ps
`include "xy_seq_cfg.svh"
module xy_vector_point_sequencer (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  // Point stream in
  input  wire logic               i_pt_valid,
  input  wire xy_seq_pkg::coord_t i_pt_x,
  input  wire xy_seq_pkg::coord_t i_pt_y,
  output logic                    o_pt_ready,
  // Settings write port
  input  wire logic               i_set_we,
  input  wire logic [1:0]         i_set_sel,
  input  wire logic [11:0]        i_set_data,
  // Settings query port
  input  wire logic               i_query,
  output logic                    o_query_valid,
  output logic [11:0]             o_query_data,
  // Converter and beam outputs
  output xy_seq_pkg::coord_t      o_dac_x,
  output logic                    o_dac_x_we,
  output xy_seq_pkg::coord_t      o_dac_y,
  output logic                    o_dac_y_we,
  output logic                    o_beam_on,
  // Status
  output logic                    o_busy,
  output logic [11:0]             o_threshold,
  output xy_seq_pkg::count_t      o_small_count,
  output xy_seq_pkg::count_t      o_large_count,
  output xy_seq_pkg::count_t      o_unblank_count
);
  import xy_seq_pkg::*;

  // Cycles per idle step and fixed overhead, derived from the clock rate
  localparam int unsigned STEP_CYC_I = `XY_IDLE_STEP_CYC;
  localparam int unsigned OVH_CYC_I  = `XY_OVERHEAD_CYC;
  localparam logic [15:0] STEP_CYC   = 16'(STEP_CYC_I);
  // Load X and load Y states take two of the overhead cycles
  localparam logic [15:0] OVH_WAIT   = 16'(OVH_CYC_I - 2);

  // Settings selector codes
  localparam logic [1:0] SEL_THRESH  = 2'h0;
  localparam logic [1:0] SEL_SMALL   = 2'h1;
  localparam logic [1:0] SEL_LARGE   = 2'h2;
  localparam logic [1:0] SEL_UNBLANK = 2'h3;

  // Settings registers
  logic [11:0] thresh_reg, thresh_next;        // Step-size threshold
  count_t      small_reg, small_next;          // Short settling count
  count_t      large_reg, large_next;          // Long settling count
  count_t      unblank_reg, unblank_next;      // Beam pulse count
  logic        qv_reg, qv_next;                // Query answer strobe
  logic [11:0] qd_reg, qd_next;                // Query answer data

  // Settings update and query answer
  always_comb begin
    thresh_next  = thresh_reg;
    small_next   = small_reg;
    large_next   = large_reg;
    unblank_next = unblank_reg;
    qv_next      = 1'b0;
    qd_next      = qd_reg;
    // R9 runtime setting update
    if (i_set_we) begin
      case (i_set_sel)
        SEL_THRESH:  thresh_next  = i_set_data;
        SEL_SMALL:   small_next   = i_set_data[7:0];
        SEL_LARGE:   large_next   = i_set_data[7:0];
        SEL_UNBLANK: unblank_next = i_set_data[7:0];
        default:     thresh_next  = thresh_reg;
      endcase
    end
    // R10 report pulse count
    if (i_query) begin
      qv_next = 1'b1;
      qd_next = {4'h0, unblank_reg};
    end
  end

  // Settings registers, reset to the start-up values
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      thresh_reg  <= `XY_THRESH_RST;
      small_reg   <= `XY_SMALL_RST;
      large_reg   <= `XY_LARGE_RST;
      unblank_reg <= `XY_UNBLANK_RST;
      qv_reg      <= 1'b0;
      qd_reg      <= 12'h000;
    end else begin
      thresh_reg  <= thresh_next;
      small_reg   <= small_next;
      large_reg   <= large_next;
      unblank_reg <= unblank_next;
      qv_reg      <= qv_next;
      qd_reg      <= qd_next;
    end
  end

  // Sequencer state
  seq_state_e  state_reg, state_next;          // Current phase of a point
  coord_t      px_reg, px_next;                // Pending X
  coord_t      py_reg, py_next;                // Pending Y
  coord_t      dx_reg, dx_next;                // Converter X value
  coord_t      dy_reg, dy_next;                // Converter Y value
  logic        dxw_reg, dxw_next;              // X converter write strobe
  logic        dyw_reg, dyw_next;              // Y converter write strobe
  logic        beam_reg, beam_next;            // Beam enable
  logic        long_reg, long_next;            // Long settle chosen
  logic [15:0] sub_reg, sub_next;              // Cycles within a step
  logic [15:0] cnt_reg, cnt_next;              // Steps left in a phase, cycles left in the overhead
  logic        ovh_reg, ovh_next;              // Still in fixed overhead

  // Absolute per-axis moves from the current converter values
  logic [11:0] mag_x;
  logic [11:0] mag_y;
  logic        is_long;
  always_comb begin
    // R14 absolute axis difference
    mag_x = (px_reg >= dx_reg) ? (px_reg - dx_reg) : (dx_reg - px_reg);
    mag_y = (py_reg >= dy_reg) ? (py_reg - dy_reg) : (dy_reg - py_reg);
    // R5 threshold compare
    is_long = (mag_x >= thresh_reg) || (mag_y >= thresh_reg);
  end

  // Next-state logic of the point sequence
  always_comb begin
    state_next = state_reg;
    px_next    = px_reg;
    py_next    = py_reg;
    dx_next    = dx_reg;
    dy_next    = dy_reg;
    dxw_next   = 1'b0;
    dyw_next   = 1'b0;
    beam_next  = beam_reg;
    long_next  = long_reg;
    sub_next   = sub_reg;
    cnt_next   = cnt_reg;
    ovh_next   = ovh_reg;
    case (state_reg)
      // Wait for a point; coordinates are 12 bits so 0..4095 by width
      ST_IDLE: begin
        beam_next = 1'b0;
        // R11 coordinate range
        if (i_pt_valid) begin
          px_next    = i_pt_x;
          py_next    = i_pt_y;
          state_next = ST_LOAD_X;
        end
      end
      // R12 write X first
      ST_LOAD_X: begin
        long_next  = is_long;
        dx_next    = px_reg;
        dxw_next   = 1'b1;
        state_next = ST_LOAD_Y;
      end
      // R12 then write Y
      ST_LOAD_Y: begin
        dy_next    = py_reg;
        dyw_next   = 1'b1;
        ovh_next   = 1'b1;
        sub_next   = 16'h0000;
        cnt_next   = OVH_WAIT;
        state_next = ST_SETTLE;
      end
      // R3 beam stays low while settling
      ST_SETTLE: begin
        beam_next = 1'b0;
        if (ovh_reg) begin
          // R2 fixed transfer overhead
          // R7 overhead sets minimum period
          if (cnt_reg == 16'h0000) begin
            ovh_next = 1'b0;
            // R4 pick short or long count
            cnt_next = {8'h00, long_reg ? large_reg : small_reg};
          end else begin
            cnt_next = cnt_reg - 16'h0001;
          end
        // R6 one idle step per count
        end else if (cnt_reg == 16'h0000) begin
          // R12 beam after settling
          beam_next  = 1'b1;
          cnt_next   = {8'h00, unblank_reg};
          sub_next   = 16'h0000;
          state_next = ST_BEAM;
        end else if (sub_reg == STEP_CYC - 16'h0001) begin
          sub_next = 16'h0000;
          cnt_next = cnt_reg - 16'h0001;
        end else begin
          sub_next = sub_reg + 16'h0001;
        end
      end
      // R1 pulse width from count, one cycle minimum
      ST_BEAM: begin
        if (cnt_reg == 16'h0000) begin
          beam_next  = 1'b0;
          state_next = ST_OFF;
        end else if (sub_reg == STEP_CYC - 16'h0001) begin
          sub_next = 16'h0000;
          cnt_next = cnt_reg - 16'h0001;
        end else begin
          sub_next = sub_reg + 16'h0001;
        end
      end
      // R13 beam low before next point
      ST_OFF: begin
        beam_next  = 1'b0;
        state_next = ST_IDLE;
      end
      default: begin
        beam_next  = 1'b0;
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= ST_IDLE;
      px_reg    <= 12'h000;
      py_reg    <= 12'h000;
      dx_reg    <= 12'h000;
      dy_reg    <= 12'h000;
      dxw_reg   <= 1'b0;
      dyw_reg   <= 1'b0;
      beam_reg  <= 1'b0;
      long_reg  <= 1'b0;
      sub_reg   <= 16'h0000;
      cnt_reg   <= 16'h0000;
      ovh_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      px_reg    <= px_next;
      py_reg    <= py_next;
      dx_reg    <= dx_next;
      dy_reg    <= dy_next;
      dxw_reg   <= dxw_next;
      dyw_reg   <= dyw_next;
      beam_reg  <= beam_next;
      long_reg  <= long_next;
      sub_reg   <= sub_next;
      cnt_reg   <= cnt_next;
      ovh_reg   <= ovh_next;
    end
  end

  // Outputs
  // R8 ready as soon as idle, no added gaps
  assign o_pt_ready      = (state_reg == ST_IDLE);
  assign o_busy          = (state_reg != ST_IDLE);
  assign o_dac_x         = dx_reg;
  assign o_dac_x_we      = dxw_reg;
  assign o_dac_y         = dy_reg;
  assign o_dac_y_we      = dyw_reg;
  assign o_beam_on       = beam_reg;
  assign o_query_valid   = qv_reg;
  assign o_query_data    = qd_reg;
  assign o_threshold     = thresh_reg;
  assign o_small_count   = small_reg;
  assign o_large_count   = large_reg;
  assign o_unblank_count = unblank_reg;
endmodule : xy_vector_point_sequencer

/* tb/xy_seq_monitor.sv */
// Port timing checker of the X-Y point sequencer
`timescale 1ns/1ps
module xy_seq_monitor (
  // Clock, reset and inputs
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_pt_valid,
  input wire logic        i_set_we,
  input wire logic [1:0]  i_set_sel,
  input wire logic [11:0] i_set_data,
  input wire logic        i_query,
  // Outputs watched
  input wire logic        o_pt_ready,
  input wire logic        o_query_valid,
  input wire logic [11:0] o_query_data,
  input wire logic        o_dac_x_we,
  input wire logic        o_dac_y_we,
  input wire logic        o_beam_on,
  input wire logic [7:0]  o_small_count,
  input wire logic [7:0]  o_large_count,
  input wire logic [7:0]  o_unblank_count
);
  logic [15:0] dark_reg;  // Cycles since the Y load
  logic [15:0] lit_reg;   // Cycles with the beam on
  // Helper counters for settle and pulse length
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dark_reg <= 16'h0000;
      lit_reg  <= 16'h0000;
    end else begin
      dark_reg <= o_dac_y_we ? 16'h0001 : dark_reg + 16'h0001;
      lit_reg  <= o_beam_on ? lit_reg + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence load_seq;
    o_dac_x_we ##1 o_dac_y_we;
  endsequence
  load_order_a: assert property (i_pt_valid && o_pt_ready |=> ##1 load_seq)
    else $error("converter loads out of order");
  dark_settle_a: assert property (o_dac_y_we |=> (!o_beam_on)[*8])
    else $error("beam on during settling");
  settle_len_a: assert property ($rose(o_beam_on) |->
    dark_reg == 16'd50 + 3 * o_small_count || dark_reg == 16'd50 + 3 * o_large_count)
    else $error("settle length wrong");
  pulse_len_a: assert property ($fell(o_beam_on) |-> lit_reg == 3 * o_unblank_count + 1)
    else $error("beam pulse width wrong");
  beam_idle_a: assert property ($fell(o_beam_on) |-> !o_pt_ready ##1 o_pt_ready)
    else $error("ready not back after beam off");
  busy_dark_a: assert property (o_beam_on |-> !o_pt_ready)
    else $error("ready while beam on");
  query_ans_a: assert property (i_query |=> o_query_valid &&
    o_query_data == {4'h0, $past(o_unblank_count)})
    else $error("query answer wrong");
  pulse_set_a: assert property (i_set_we && i_set_sel == 2'd3 |=>
    o_unblank_count == $past(i_set_data[7:0]))
    else $error("pulse count not updated");
  large_set_a: assert property (i_set_we && i_set_sel == 2'd2 |=>
    o_large_count == $past(i_set_data[7:0]))
    else $error("long count not updated");
endmodule : xy_seq_monitor
bind xy_vector_point_sequencer xy_seq_monitor mon (.*);

/* tb/xy_scope_model.sv */
// Converter pair and beam input model that measures each dot
`timescale 1ns/1ps
module xy_scope_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Converter and beam lines
  input  wire logic [11:0] i_dac_x,
  input  wire logic        i_dac_x_we,
  input  wire logic [11:0] i_dac_y,
  input  wire logic        i_dac_y_we,
  input  wire logic        i_beam_on,
  // Measurements
  output logic [11:0]      o_lat_x,
  output logic [11:0]      o_lat_y,
  output logic [15:0]      o_settle,
  output logic [15:0]      o_pulse,
  output logic [7:0]       o_dots
);
  logic [15:0] sc;  // Dark cycles since Y load
  logic [15:0] pc;  // Lit cycles
  logic        bd;  // Beam one cycle ago
  // latch loads, time dark and lit spans
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      {o_lat_x, o_lat_y, o_settle, o_pulse, o_dots, sc, pc, bd} <= '0;
    end else begin
      if (i_dac_x_we) o_lat_x <= i_dac_x;
      if (i_dac_y_we) o_lat_y <= i_dac_y;
      sc <= i_dac_y_we ? 16'h0001 : sc + 16'h0001;
      pc <= i_beam_on ? pc + 16'h0001 : 16'h0000;
      bd <= i_beam_on;
      if (i_beam_on && !bd) o_settle <= sc;
      if (!i_beam_on && bd) begin
        o_pulse <= pc;
        o_dots  <= o_dots + 8'h01;
      end
    end
  end
endmodule : xy_scope_model

/* tb/tb_xy_vector_point_sequencer.sv */
// Self-checking bench of the X-Y point sequencer
`timescale 1ns/1ps
module tb_xy_vector_point_sequencer;
  import xy_seq_pkg::*;
  logic clk = 0, rstn = 0, pv = 0, we = 0, q = 0;
  logic [1:0] sel = 2'h0;
  logic [11:0] sd = 12'h000;
  coord_t px = 12'h000, py = 12'h000, dx, dy, lx, ly;
  logic rdy, qv, xwe, ywe, beam, busy;
  logic [11:0] qd, thr;
  count_t sm, lg, ub;
  count_t sh_sm = 8'h19, sh_lg = 8'h32;  // Settle counts the bench has written
  logic [15:0] settle, pulse;
  logic [7:0] dots;
  int err_count = 0, samples_checked = 0;
  logic [24:0] tbl [9] = '{{12'd999, 12'd0, 1'b0}, {12'd999, 12'd999, 1'b0},
    {12'd1999, 12'd999, 1'b1}, {12'd0, 12'd999, 1'b1}, {12'd0, 12'd1999, 1'b1},
    {12'd4095, 12'd4095, 1'b1}, {12'd4095, 12'd4095, 1'b0},
    {12'd4090, 12'd4095, 1'b1}, {12'd4086, 12'd4095, 1'b0}};
  xy_vector_point_sequencer uut (.i_clk(clk), .i_rstn(rstn), .i_pt_valid(pv), .i_pt_x(px),
    .i_pt_y(py), .o_pt_ready(rdy), .i_set_we(we), .i_set_sel(sel), .i_set_data(sd),
    .i_query(q), .o_query_valid(qv), .o_query_data(qd), .o_dac_x(dx), .o_dac_x_we(xwe),
    .o_dac_y(dy), .o_dac_y_we(ywe), .o_beam_on(beam), .o_busy(busy), .o_threshold(thr),
    .o_small_count(sm), .o_large_count(lg), .o_unblank_count(ub));
  xy_scope_model scope (.i_clk(clk), .i_rstn(rstn), .i_dac_x(dx), .i_dac_x_we(xwe),
    .i_dac_y(dy), .i_dac_y_we(ywe), .i_beam_on(beam), .o_lat_x(lx), .o_lat_y(ly),
    .o_settle(settle), .o_pulse(pulse), .o_dots(dots));
  // Clock
  initial begin
    forever #5 clk = ~clk;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task summarize;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task set_val(input logic [1:0] s, input logic [11:0] d);
    @(posedge clk);
    we <= 1'b1; sel <= s; sd <= d;
    @(posedge clk);
    we <= 1'b0;
    if (s == 2'd1) sh_sm = d[7:0];
    if (s == 2'd2) sh_lg = d[7:0];
  endtask : set_val
  // Send one point, wait for its dot, judge settle and pulse
  task do_point(input coord_t x, input coord_t y, input logic big, input logic [15:0] pw);
    logic [7:0] d0;
    int i;
    d0 = dots;
    @(posedge clk);
    pv <= 1'b1; px <= x; py <= y;
    for (i = 0; i < 20 && rdy !== 1'b1; i++) @(posedge clk);
    chk(rdy, 1'b1);
    @(posedge clk);
    pv <= 1'b0;
    #1;
    chk(busy, 1'b1);
    for (i = 0; i < 1000 && dots === d0; i++) @(posedge clk);
    if (i == 1000) begin
      err_count++;
      summarize();
    end
    repeat (3) @(posedge clk);
    chk(lx, x);
    chk(ly, y);
    chk(settle, 16'd50 + 3 * (big ? sh_lg : sh_sm));
    chk(pulse, pw);
  endtask : do_point
  task t_reset;
    chk(thr, 12'h3e8);
    chk({sm, lg}, 16'h1932);
    chk(ub, 8'h05);
  endtask : t_reset
  task t_steps;
    set_val(2'd1, 12'h001);
    set_val(2'd2, 12'h004);
    set_val(2'd3, 12'h002);
    for (int k = 0; k < 9; k++) begin
      if (k == 7) set_val(2'd0, 12'h005);
      do_point(tbl[k][24:13], tbl[k][12:1], tbl[k][0], 16'd7);
    end
    set_val(2'd1, 12'h000);
    do_point(12'd4086, 12'd4094, 1'b0, 16'd7);
  endtask : t_steps
  task t_pulse;
    set_val(2'd3, 12'h000);
    do_point(12'd4086, 12'd4094, 1'b0, 16'd1);
    set_val(2'd3, 12'h004);
    do_point(12'd4086, 12'd4094, 1'b0, 16'd13);
  endtask : t_pulse
  task t_query;
    @(posedge clk);
    q <= 1'b1;
    @(posedge clk);
    q <= 1'b0;
    #1;
    chk({qv, qd}, {1'b1, 12'h004});
  endtask : t_query
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_steps();
    t_pulse();
    t_query();
    summarize();
  end
endmodule : tb_xy_vector_point_sequencer
